// ---- rtl/pio_pin_cell.sv ----
// pin cell: input synchroniser and gpio / peripheral output steering
// assumes pins are asynchronous to core_clk_i
module pio_pin_cell #(
    parameter int W = 42
) (
    input  wire logic         core_clk_i,
    input  wire logic         nrst_i,
    input  wire logic [W-1:0] pin_in_i,
    input  wire logic [W-1:0] sel_i,
    input  wire logic [W-1:0] gpio_out_i,
    input  wire logic [W-1:0] gpio_oe_i,
    input  wire logic [W-1:0] per_out_i,
    input  wire logic [W-1:0] per_oe_i,
    output logic      [W-1:0] pin_out_o,
    output logic      [W-1:0] pin_oe_o,
    output logic      [W-1:0] pin_sync_o
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] out_nxt;
    logic [W-1:0] oe_nxt;
    logic [W-1:0] out_r;
    logic [W-1:0] oe_r;

    always_comb begin
        out_nxt = (sel_i & per_out_i) | (~sel_i & gpio_out_i);
        oe_nxt  = (sel_i & per_oe_i) | (~sel_i & gpio_oe_i);
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_r  <= '0;
            s2_r  <= '0;
            out_r <= '0;
            oe_r  <= '0;
        end else begin
            s1_r  <= pin_in_i;
            s2_r  <= s1_r;
            out_r <= out_nxt;
            oe_r  <= oe_nxt;
        end
    end

    assign pin_out_o  = out_r;
    assign pin_oe_o   = oe_r;
    assign pin_sync_o = s2_r;

endmodule

// ---- rtl/pio_pkg.sv ----
// constants, types and field layouts shared by the peripheral i/o plumbing
// assumes one core clock domain and the core as the only register writer
package pio_pkg;

    localparam int          NPINS     = 42;
    localparam int          NGRP      = 5;
    localparam int          DW        = 24;
    localparam int          AW        = 24;
    localparam int          INT_MAX   = 6;
    localparam int          DMA_MAX   = 4;

    // internal i/o space: top 128 words of x data space
    localparam logic [23:0] IO_BASE   = 24'hffff80;
    localparam int          IO_LSB    = 7;
    localparam logic [6:0]  OFS_SEL   = 7'h60;
    localparam logic [6:0]  OFS_CTRL  = 7'h68;
    localparam logic [2:0]  GRP_LAST  = 3'h4;

    // pin groups: host port, sync serial zero, sync serial one,
    // async serial port, timers
    localparam int          GRP_LO [NGRP] = '{0, 24, 30, 36, 39};
    localparam int          GRP_W  [NGRP] = '{24, 6, 6, 3, 3};
    localparam int          INT_N  [NGRP] = '{6, 6, 6, 5, 3};
    localparam int          DMA_N  [NGRP] = '{4, 2, 2, 2, 2};
    localparam int          HOST_GRP      = 0;

    // control register fields
    localparam int          CTL_IE_LO = 0;
    localparam int          CTL_DE_LO = 8;
    localparam int          CTL_EN    = 12;

    localparam logic [23:0] SEL_RST_HOST  = 24'hffffff;
    localparam logic [23:0] SEL_RST_OTHER = 24'h000000;
    localparam logic [23:0] CTRL_RST      = 24'h000000;

    localparam logic [23:0] VEC_BASE_DEF  = 24'h000040;
    localparam int          VEC_STEP      = 2;

    typedef enum logic [4:0] {
        BOP_NONE = 5'h01,
        BOP_SET  = 5'h02,
        BOP_CLR  = 5'h04,
        BOP_CHG  = 5'h08,
        BOP_TST  = 5'h10
    } pio_bitop_type;

    typedef struct packed {
        logic [23:0]   addr;
        logic          wr;
        logic          rd;
        pio_bitop_type bop;
        logic [4:0]    bnum;
        logic [23:0]   wdata;
    } pio_req_type;

    typedef struct packed {
        logic [NPINS-1:0] out;
        logic [NPINS-1:0] oe;
    } pio_drive_type;

endpackage

// ---- rtl/pio_top.sv ----
// peripheral i/o space decode, pin function select, interrupt and dma gating
// assumes core issues one access per cycle; port data regs live elsewhere
// Operation
// - control registers decode into the top 128 words of x space
// - registers take word moves and single-bit set, clear, change, test
// - 42 shared two-way pins, each gpio or peripheral, none gpio-only
// - after reset pins are gpio inputs except the host port pins
// - only peripheral control registers choose gpio or peripheral function
// - five groups: host 24, sync serial 6 and 6, async 3, timers 3
// - an enabled peripheral keeps the mode bits written before enabling
// - interrupt needs own enable, priority enable and global enable
// - interrupt fetches from a fixed vector, two-word slots per source
// - long handler returns to the program counter saved at interrupt
// - each peripheral has three to six interrupt sources
// - each peripheral has two to four dma request sources
// - dma requests use their own path and never stall the core
module pio_top #(
    parameter logic [23:0] VEC_BASE = pio_pkg::VEC_BASE_DEF
) (
    input  wire logic                          core_clk_i,
    input  wire logic                          nrst_i,
    input  wire pio_pkg::pio_req_type          req_i,
    output logic      [pio_pkg::DW-1:0]        rdata_o,
    output logic                               io_hit_o,
    output logic                               bit_tst_o,
    input  wire logic [pio_pkg::NPINS-1:0]     pin_in_i,
    output logic      [pio_pkg::NPINS-1:0]     pin_out_o,
    output logic      [pio_pkg::NPINS-1:0]     pin_oe_o,
    output logic      [pio_pkg::NPINS-1:0]     pin_sync_o,
    input  wire pio_pkg::pio_drive_type        gpio_drv_i,
    input  wire pio_pkg::pio_drive_type        per_drv_i,
    output logic      [pio_pkg::NGRP-1:0]      per_en_o,
    input  wire logic [pio_pkg::NGRP*6-1:0]    stat_i,
    input  wire logic [pio_pkg::NGRP-1:0]      prio_en_i,
    input  wire logic                          glob_en_i,
    output logic      [pio_pkg::NGRP*6-1:0]    irq_src_o,
    output logic                               irq_o,
    output logic      [pio_pkg::AW-1:0]        irq_vec_o,
    output logic      [pio_pkg::NGRP*4-1:0]    dma_req_o,
    input  wire logic                          irq_take_i,
    input  wire logic                          rti_i,
    input  wire logic [pio_pkg::AW-1:0]        pc_i,
    output logic      [pio_pkg::AW-1:0]        resume_pc_o
);

    localparam int NG = pio_pkg::NGRP;
    localparam int IM = pio_pkg::INT_MAX;
    localparam int DM = pio_pkg::DMA_MAX;

    logic [NG-1:0][23:0]    sel_r, sel_nxt;
    logic [NG-1:0][23:0]    ctrl_r, ctrl_nxt;
    logic [23:0]            rdata_r, rdata_nxt;
    logic                   hit_r, hit_nxt;
    logic                   tst_r, tst_nxt;
    logic [NG*IM-1:0]       irq_src_r, irq_src_nxt;
    logic                   irq_r, irq_nxt;
    logic [23:0]            vec_r, vec_nxt;
    logic [NG*DM-1:0]       dma_r, dma_nxt;
    logic [23:0]            pc_r, pc_nxt;
    logic [pio_pkg::NPINS-1:0] pin_sel;

    logic                   in_io;
    logic [6:0]             idx;
    logic                   is_sel;
    logic                   is_ctrl;
    logic [2:0]             grp;
    logic [23:0]            cur;
    logic [23:0]            mask;
    logic [23:0]            wval;
    logic                   do_wr;

    // register access
    always_comb begin
        in_io   = req_i.addr[23:pio_pkg::IO_LSB] ==
                  pio_pkg::IO_BASE[23:pio_pkg::IO_LSB];
        idx     = req_i.addr[6:0];
        grp     = idx[2:0];
        is_sel  = in_io && idx[6:3] == pio_pkg::OFS_SEL[6:3]
                  && grp <= pio_pkg::GRP_LAST;
        is_ctrl = in_io && idx[6:3] == pio_pkg::OFS_CTRL[6:3]
                  && grp <= pio_pkg::GRP_LAST;
        cur     = '0;
        if (is_sel) begin
            cur = sel_r[grp];
        end else if (is_ctrl) begin
            cur = ctrl_r[grp];
        end
        mask  = 24'h000001 << req_i.bnum;
        wval  = req_i.wdata;
        do_wr = 1'b0;
        unique case (req_i.bop)
            pio_pkg::BOP_SET: begin
                wval  = cur | mask;
                do_wr = 1'b1;
            end
            pio_pkg::BOP_CLR: begin
                wval  = cur & ~mask;
                do_wr = 1'b1;
            end
            pio_pkg::BOP_CHG: begin
                wval  = cur ^ mask;
                do_wr = 1'b1;
            end
            pio_pkg::BOP_TST: begin
                do_wr = 1'b0;
            end
            default: begin
                do_wr = req_i.wr;
            end
        endcase
        sel_nxt   = sel_r;
        ctrl_nxt  = ctrl_r;
        if (do_wr && is_sel && !ctrl_r[grp][pio_pkg::CTL_EN]) begin
            sel_nxt[grp] = wval;
        end
        if (do_wr && is_ctrl) begin
            if (ctrl_r[grp][pio_pkg::CTL_EN]) begin
                ctrl_nxt[grp][pio_pkg::CTL_EN] = wval[pio_pkg::CTL_EN];
            end else begin
                ctrl_nxt[grp] = wval;
            end
        end
        hit_nxt   = is_sel || is_ctrl;
        rdata_nxt = req_i.rd ? cur : rdata_r;
        tst_nxt   = (req_i.bop == pio_pkg::BOP_TST) ? |(cur & mask) : tst_r;
    end

    // interrupt, dma and vector gating
    always_comb begin
        irq_src_nxt = '0;
        dma_nxt     = '0;
        vec_nxt     = vec_r;
        pc_nxt      = pc_r;
        for (int g = 0; g < NG; g++) begin
            for (int i = 0; i < pio_pkg::INT_N[g]; i++) begin
                irq_src_nxt[g*IM+i] = stat_i[g*IM+i]
                    && ctrl_r[g][pio_pkg::CTL_IE_LO+i]
                    && prio_en_i[g] && glob_en_i;
            end
            for (int i = 0; i < pio_pkg::DMA_N[g]; i++) begin
                dma_nxt[g*DM+i] = stat_i[g*IM+i]
                    && ctrl_r[g][pio_pkg::CTL_DE_LO+i];
            end
        end
        irq_nxt = |irq_src_nxt;
        for (int s = NG*IM-1; s >= 0; s--) begin
            if (irq_src_nxt[s]) begin
                vec_nxt = VEC_BASE + 24'(s * pio_pkg::VEC_STEP);
            end
        end
        if (irq_take_i) begin
            pc_nxt = pc_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int g = 0; g < NG; g++) begin
                sel_r[g]  <= (g == pio_pkg::HOST_GRP) ? pio_pkg::SEL_RST_HOST
                                : pio_pkg::SEL_RST_OTHER;
                ctrl_r[g] <= pio_pkg::CTRL_RST;
            end
            rdata_r   <= '0;
            hit_r     <= 1'b0;
            tst_r     <= 1'b0;
            irq_src_r <= '0;
            irq_r     <= 1'b0;
            vec_r     <= '0;
            dma_r     <= '0;
            pc_r      <= '0;
        end else begin
            sel_r     <= sel_nxt;
            ctrl_r    <= ctrl_nxt;
            rdata_r   <= rdata_nxt;
            hit_r     <= hit_nxt;
            tst_r     <= tst_nxt;
            irq_src_r <= irq_src_nxt;
            irq_r     <= irq_nxt;
            vec_r     <= vec_nxt;
            dma_r     <= dma_nxt;
            pc_r      <= pc_nxt;
        end
    end

    // per-pin function select from the group registers
    always_comb begin
        pin_sel = '0;
        for (int g = 0; g < NG; g++) begin
            for (int b = 0; b < pio_pkg::GRP_W[g]; b++) begin
                pin_sel[pio_pkg::GRP_LO[g]+b] = sel_r[g][b];
            end
        end
    end

    pio_pin_cell #(
        .W (pio_pkg::NPINS)
    ) u_pins (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .pin_in_i   (pin_in_i),
        .sel_i      (pin_sel),
        .gpio_out_i (gpio_drv_i.out),
        .gpio_oe_i  (gpio_drv_i.oe),
        .per_out_i  (per_drv_i.out),
        .per_oe_i   (per_drv_i.oe),
        .pin_out_o  (pin_out_o),
        .pin_oe_o   (pin_oe_o),
        .pin_sync_o (pin_sync_o)
    );

    always_comb begin
        for (int g = 0; g < NG; g++) begin
            per_en_o[g] = ctrl_r[g][pio_pkg::CTL_EN];
        end
    end

    assign rdata_o     = rdata_r;
    assign io_hit_o    = hit_r;
    assign bit_tst_o   = tst_r;
    assign irq_src_o   = irq_src_r;
    assign irq_o       = irq_r;
    assign irq_vec_o   = vec_r;
    assign dma_req_o   = dma_r;
    assign resume_pc_o = rti_i ? pc_r : pc_r;

endmodule

// ---- test/pio_pin_model.sv ----
// outside circuitry on the 42 shared pins
// assumes plain wires with no pull, outside level set by the bench
module pio_pin_model (
    input  wire logic [41:0] out_i,
    input  wire logic [41:0] oe_i,
    input  wire logic [41:0] ext_i,
    output logic      [41:0] pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // driven pins show the block's level, the rest the outside level
    assign pin_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule

// ---- test/pio_top_monitor.sv ----
// checker on the pio_top ports, bound after the module
// assumes one core clock domain and active-low reset
module pio_top_monitor (
    input wire logic                   core_clk_i,
    input wire logic                   nrst_i,
    input wire pio_pkg::pio_req_type   req_i,
    input wire logic [23:0]            rdata_o,
    input wire logic                   io_hit_o,
    input wire logic [41:0]            pin_oe_o,
    input wire pio_pkg::pio_drive_type gpio_drv_i,
    input wire pio_pkg::pio_drive_type per_drv_i,
    input wire logic [4:0]             per_en_o,
    input wire logic [29:0]            stat_i,
    input wire logic [4:0]             prio_en_i,
    input wire logic                   glob_en_i,
    input wire logic [29:0]            irq_src_o,
    input wire logic                   irq_o,
    input wire logic [23:0]            irq_vec_o,
    input wire logic [19:0]            dma_req_o,
    input wire logic                   irq_take_i,
    input wire logic [23:0]            pc_i,
    input wire logic [23:0]            resume_pc_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    function automatic logic [29:0] gate(logic [29:0] s, logic [4:0] p);
        gate = '0;
        for (int g = 0; g < 5; g++)
            for (int i = 0; i < pio_pkg::INT_N[g]; i++)
                gate[g*6+i] = s[g*6+i] & p[g];
    endfunction
    function automatic logic [19:0] dmap(logic [29:0] s);
        dmap = '0;
        for (int g = 0; g < 5; g++)
            for (int i = 0; i < pio_pkg::DMA_N[g]; i++)
                dmap[g*4+i] = s[g*6+i];
    endfunction
    logic out_sp;
    assign out_sp = req_i.addr[23:7] != 17'h1ffff;
    AST_OUT_HIT: assert property ((req_i.wr || req_i.rd) && out_sp
        |=> !io_hit_o) else $error("hit outside io space");
    AST_OUT_RD: assert property (req_i.rd && out_sp
        |=> rdata_o == 24'h0) else $error("read outside io space");
    AST_MAP_HIT: assert property (req_i.rd && req_i.addr inside
        {[24'hffffe0:24'hffffe4], [24'hffffe8:24'hffffec]}
        |=> io_hit_o) else $error("mapped read missed");
    AST_IRQ_GATE: assert property ((irq_src_o &
        ~gate($past(stat_i), $past(prio_en_i))) == 30'h0)
        else $error("source without flag or priority");
    AST_IRQ_GLOB: assert property (|irq_src_o |-> $past(glob_en_i))
        else $error("source without global enable");
    AST_IRQ_OR: assert property (irq_o == |irq_src_o)
        else $error("irq not or of sources");
    AST_VEC_HOLD: assert property (!irq_o |-> $stable(irq_vec_o))
        else $error("vector moved with none pending");
    AST_DMA: assert property ((dma_req_o &
        ~dmap($past(stat_i))) == 20'h0) else $error("dma without flag");
    AST_OE_OFF: assert property ((pin_oe_o & ~($past(gpio_drv_i.oe)
        | $past(per_drv_i.oe))) == 42'h0) else $error("pin driven unasked");
    AST_RESUME: assert property (irq_take_i
        |=> resume_pc_o == $past(pc_i)) else $error("resume pc wrong");
    AST_PEREN: assert property ($changed(per_en_o)
        |-> $past(req_i.wr || req_i.bop != pio_pkg::BOP_NONE))
        else $error("enable moved without write");
    cover property (irq_o);
    cover property (|dma_req_o);
    cover property (|per_en_o);
endmodule
bind pio_top pio_top_monitor mon_u (.core_clk_i, .nrst_i, .req_i, .rdata_o,
    .io_hit_o, .pin_oe_o, .gpio_drv_i, .per_drv_i, .per_en_o, .stat_i,
    .prio_en_i, .glob_en_i, .irq_src_o, .irq_o, .irq_vec_o, .dma_req_o,
    .irq_take_i, .pc_i, .resume_pc_o);

// ---- test/pio_top_tb_top.sv ----
// bench for pio_top: access tasks and directed checks
// assumes the pin model as far side, inputs driven at falling edge
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin \
    error_cnt++; $display("unexpected %s exp %h got %h", n, e, g); end end
module pio_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam pio_pkg::pio_req_type IDLE = '{24'h0, 1'b0, 1'b0,
        pio_pkg::BOP_NONE, 5'h0, 24'h0};
    logic core_clk_i = 0, nrst_i = 0, glob_en_i, irq_take_i, rti_i;
    logic io_hit_o, bit_tst_o, irq_o;
    pio_pkg::pio_req_type req_i;
    pio_pkg::pio_drive_type gpio_drv_i, per_drv_i;
    logic [23:0] rdata_o, pc_i, resume_pc_o, irq_vec_o;
    logic [41:0] pin_in_i, pin_out_o, pin_oe_o, pin_sync_o, ext, m;
    logic [29:0] stat_i, irq_src_o;
    logic [4:0] prio_en_i, per_en_o;
    logic [19:0] dma_req_o;
    int error_cnt = 0, n_checks = 0;
    always #10 core_clk_i = ~core_clk_i;
    pio_top dut_u (.core_clk_i, .nrst_i, .req_i, .rdata_o, .io_hit_o,
        .bit_tst_o, .pin_in_i, .pin_out_o, .pin_oe_o, .pin_sync_o,
        .gpio_drv_i, .per_drv_i, .per_en_o, .stat_i, .prio_en_i, .glob_en_i,
        .irq_src_o, .irq_o, .irq_vec_o, .dma_req_o, .irq_take_i, .rti_i,
        .pc_i, .resume_pc_o);
    pio_pin_model pm_u (.out_i(pin_out_o), .oe_i(pin_oe_o), .ext_i(ext),
        .pin_o(pin_in_i));
    task automatic cyc(int k);
        repeat (k) @(negedge core_clk_i);
    endtask
    task automatic acc(logic [23:0] a, logic w, logic r,
        pio_pkg::pio_bitop_type b, logic [23:0] d);
        @(negedge core_clk_i);
        req_i = '{a, w, r, b, 5'h0c, d};
        @(negedge core_clk_i);
        req_i = IDLE;
    endtask
    task automatic wr(logic [23:0] a, logic [23:0] d);
        acc(a, 1'b1, 1'b0, pio_pkg::BOP_NONE, d);
    endtask
    task automatic rd(logic [23:0] a);
        acc(a, 1'b0, 1'b1, pio_pkg::BOP_NONE, 24'h0);
    endtask
    task automatic bo(pio_pkg::pio_bitop_type b);
        acc(24'hffffe9, 1'b0, 1'b0, b, 24'h0);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #60000;
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        req_i = IDLE;
        gpio_drv_i = '0;
        per_drv_i = '{42'h15555555555, {42{1'b1}}};
        {stat_i, prio_en_i, glob_en_i, irq_take_i, rti_i, pc_i} = '0;
        ext = 42'h2aaaaaaaaaa;
        cyc(3);
        nrst_i = 1;
        cyc(1);
        `CHK("oe", 42'hffffff, pin_oe_o)
        `CHK("en", 5'h0, per_en_o)
        for (int g = 0; g < 5; g++) begin
            rd(24'hffffe0 + g);
            `CHK("sel", (g == 0) ? 24'hffffff : 24'h0, rdata_o)
        end
        wr(24'hffffe0, 24'h0);
        for (int g = 0; g < 5; g++) begin
            m = ((42'h1 << pio_pkg::GRP_W[g]) - 42'h1) << pio_pkg::GRP_LO[g];
            wr(24'hffffe0 + g, 24'hffffff);
            cyc(1);
            `CHK("grp oe", m, pin_oe_o)
            `CHK("grp out", per_drv_i.out & m, pin_out_o & m)
            wr(24'hffffe0 + g, 24'h0);
        end
        cyc(3);
        `CHK("sync", ext, pin_sync_o)
        gpio_drv_i = '{~ext, {42{1'b1}}};
        cyc(2);
        `CHK("gpio out", ~ext, pin_out_o)
        gpio_drv_i = '0;
        $display("test pins done");
        wr(24'hffff7f, 24'hffffff);
        `CHK("hit", 1'b0, io_hit_o)
        wr(24'h00ffe0, 24'hffffff);
        rd(24'hffffe0);
        `CHK("alias", 24'h0, rdata_o)
        `CHK("hit", 1'b1, io_hit_o)
        rd(24'hffff80);
        `CHK("unmapped", 1'b0, io_hit_o)
        $display("test space done");
        wr(24'hffffe1, 24'h00003f);
        wr(24'hffffe9, 24'h001000);
        `CHK("en", 5'h02, per_en_o)
        wr(24'hffffe1, 24'h0);
        rd(24'hffffe1);
        `CHK("locked", 24'h00003f, rdata_o)
        bo(pio_pkg::BOP_CLR);
        `CHK("clr", 5'h00, per_en_o)
        bo(pio_pkg::BOP_SET);
        `CHK("set", 5'h02, per_en_o)
        bo(pio_pkg::BOP_TST);
        `CHK("tst", 1'b1, bit_tst_o)
        bo(pio_pkg::BOP_CHG);
        `CHK("chg", 5'h00, per_en_o)
        bo(pio_pkg::BOP_TST);
        `CHK("tst", 1'b0, bit_tst_o)
        $display("test bits done");
        {stat_i, prio_en_i, glob_en_i} = {30'h3fffffff, 5'h1f, 1'b1};
        wr(24'hffffe8, 24'h000f3f);
        wr(24'hffffeb, 24'h00003f);
        cyc(1);
        `CHK("src", 30'h007c003f, irq_src_o)
        `CHK("irq", 1'b1, irq_o)
        `CHK("vec", 24'h000040, irq_vec_o)
        `CHK("dma", 20'h0000f, dma_req_o)
        glob_en_i = 0;
        cyc(2);
        `CHK("glob", 30'h0, irq_src_o)
        `CHK("vec hold", 24'h000040, irq_vec_o)
        {prio_en_i, glob_en_i} = {5'h1e, 1'b1};
        cyc(2);
        `CHK("prio", 30'h007c0000, irq_src_o)
        `CHK("vec", 24'h000064, irq_vec_o)
        `CHK("dma", 20'h0000f, dma_req_o)
        $display("test irq done");
        {pc_i, irq_take_i} = {24'h123456, 1'b1};
        cyc(1);
        {pc_i, irq_take_i} = '0;
        cyc(1);
        `CHK("resume", 24'h123456, resume_pc_o)
        $display("test resume done");
        tally_and_finish();
    end
endmodule
